// *** csm_consts.svh ***
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH

// -----------------------------------------------------------------------------
// Clock and timing constants
// -----------------------------------------------------------------------------
// Internal clock rate in MHz, so one microsecond is this many cycles.
`define CSM_CLOCK_MHZ            10
// Dominant timeout target in microseconds, inside the 1200 to 3800 window.
`define CSM_DTO_TIME_US          2500
// Cold crank reset pulse in microseconds, inside the 20000 to 27000 window.
`define CSM_COLD_TIME_US         23000
// Warm crank reset pulse in microseconds, inside the 1000 to 1500 window.
`define CSM_WARM_TIME_US         1200
// Least low time of an external reset request in microseconds.
`define CSM_RST_IN_TIME_US       15
// Least delay from a local wake edge to the inhibit output in microseconds.
`define CSM_WAKE_TIME_US         40
// Cycle counts derived from the times; every figure is a whole cycle count.
`define CSM_DTO_CYCLES           (`CSM_DTO_TIME_US * `CSM_CLOCK_MHZ)
`define CSM_COLD_CYCLES          (`CSM_COLD_TIME_US * `CSM_CLOCK_MHZ)
`define CSM_WARM_CYCLES          (`CSM_WARM_TIME_US * `CSM_CLOCK_MHZ)
`define CSM_RST_IN_CYCLES        (`CSM_RST_IN_TIME_US * `CSM_CLOCK_MHZ)
`define CSM_WAKE_CYCLES          (`CSM_WAKE_TIME_US * `CSM_CLOCK_MHZ)
// Counter widths.
`define CSM_PULSE_W              18
`define CSM_DTO_W                16
`define CSM_SHORT_W              10
// Width of the synchroniser bank.
`define CSM_SYNC_W               13

`endif

// *** csm_pkg.sv ***
// -----------------------------------------------------------------------------
// Types shared by the mode and status logic
// -----------------------------------------------------------------------------
package csm_pkg;

    // Operating modes of the device.
    typedef enum logic [2:0] {
        CSM_SLEEP    = 3'b000,
        CSM_STANDBY  = 3'b001,
        CSM_NORMAL   = 3'b010,
        CSM_RESET    = 3'b011,
        CSM_FAILSAFE = 3'b100
    } csm_mode_e;

    // Analog monitor flags, each high while its fault is present.
    typedef struct packed {
        logic overtemp_threshold;      // Junction above shutdown threshold.
        logic io_supply_undervoltage;  // Digital I/O supply under falling limit.
        logic reg_uv;                  // Main or transceiver regulator undervoltage.
        logic reg_ov;                  // Main or transceiver regulator overvoltage.
        logic ldo3_uv;                 // 3.3 V output regulator undervoltage.
        logic ldo3_ov;                 // 3.3 V output regulator overvoltage.
    } csm_fault_s;

endpackage : csm_pkg

// *** csm_mode_status.sv ***
// What this block does
// RULE_01: Wake in sleep drives inhibit output high.
// RULE_02: Regulators off in sleep, on otherwise.
// RULE_03: Receive output undriven without I/O supply.
// RULE_04: Status high only in normal, no timeout.
// RULE_05: Status low on dominant timeout or overtemperature.
// RULE_06: Status tri-stated on I/O supply undervoltage.
// RULE_07: 5 V variant: regulator fault forces status low.
// RULE_08: 3.3 V variant: either regulator fault lowers status.
// RULE_09: Mode set by select input, timers, faults.
// RULE_10: Inhibit is driven high or floating only.
// RULE_11: Inhibit high in normal, standby; floating in sleep.
// RULE_12: Wake input reacts to both edges.
// RULE_13: Reset line pulled low in fail-safe.
// RULE_14: Cold crank events hold reset low long.
// RULE_15: Host holds reset low the minimum time.
// RULE_16: External reset gives warm crank reset pulse.
// RULE_17: Transmit falling edge starts timeout measurement.
// RULE_18: Timeout expiry disables the bus driver.
// RULE_19: Transmit rising edge clears timeout, re-enables driver.
// RULE_20: Receive output follows bus during timeout.
// RULE_21: Reset request pulse at least 15 us.
// RULE_22: Inhibit rises no sooner than 40 us.
// RULE_23: Pin inputs synchronised before any use.
// RULE_24: Timings realised as clock counters within limits.
`timescale 1ns/1ps
`include "csm_consts.svh"

module csm_mode_status
    import csm_pkg::*;
#(
    parameter int unsigned DTO_CYCLES  = `CSM_DTO_CYCLES,
    parameter int unsigned COLD_CYCLES = `CSM_COLD_CYCLES,
    parameter int unsigned WARM_CYCLES = `CSM_WARM_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_clk_en,
    input  wire logic       i_txd,                        // Transmit data, low is dominant.
    input  wire logic       i_low_power_select_n,         // Low selects sleep.
    input  wire logic       i_system_reset_line_n,        // Level seen on the reset line.
    input  wire logic       i_wake,                       // Local wake pin level.
    input  wire logic       i_bus_wake,                   // Bus wake-up pattern seen.
    input  wire logic       i_bus_dominant,               // Receiver sees a dominant bus.
    input  wire logic       i_variant_3v3,                // High on the 3.3 V variant.
    input  wire csm_fault_s i_faults,                     // Analog monitor flags.
    output logic            o_power_inhibit_out,
    output logic            o_power_inhibit_out_oe,
    output logic            o_system_reset_line_n,
    output logic            o_system_reset_line_n_oe,
    output logic            o_transceiver_ready_out,
    output logic            o_transceiver_ready_out_oe,
    output logic            o_rxd,
    output logic            o_rxd_oe,
    output logic            o_bus_driver_enable,
    output logic            o_regulator_enable,
    output logic            o_dominant_timeout,
    output csm_mode_e       o_mode
);

    // -------------------------------------------------------------------------
    // Synchronisers
    // -------------------------------------------------------------------------
    logic [`CSM_SYNC_W-1:0] sync1_ff;     // First stage, read only by stage two.
    logic [`CSM_SYNC_W-1:0] sync2_ff;     // Second stage, safe to use.
    logic                   txd_d_ff;     // Delayed transmit for edge detection.
    logic                   wake_d_ff;    // Delayed wake for edge detection.
    logic                   txd_s;
    logic                   sel_s;
    logic                   rstin_s;
    logic                   wake_s;
    logic                   buswake_s;
    logic                   busdom_s;
    logic                   v33_s;
    csm_fault_s             flt_s;

    // Every pin level passes two flip-flops before logic reads it.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            // Idle levels: transmit, select and reset line high, all else low.
            // Resetting the fault bits high would send the machine to fail-safe.
            sync1_ff  <= 13'h1C00;
            sync2_ff  <= 13'h1C00;
            txd_d_ff  <= 1'b1;
            wake_d_ff <= 1'b0;
        end else if (i_clk_en) begin
            sync1_ff  <= {i_txd, i_low_power_select_n, i_system_reset_line_n, i_wake,
                          i_bus_wake, i_bus_dominant, i_variant_3v3, i_faults}; // RULE_23
            sync2_ff  <= sync1_ff;                                           // RULE_23
            txd_d_ff  <= txd_s;
            wake_d_ff <= wake_s;
        end
    end

    assign {txd_s, sel_s, rstin_s, wake_s, buswake_s, busdom_s, v33_s} = sync2_ff[12:6];
    assign flt_s = sync2_ff[5:0];

    // -------------------------------------------------------------------------
    // Fault decoding
    // -------------------------------------------------------------------------
    logic ov_fault;     // Any overvoltage that sends the device to fail-safe.
    logic uv_fault;     // Any regulator undervoltage that sends it to reset.
    logic volt_fault;   // Any regulator fault that lowers the status output.

    // The 3.3 V part watches both regulators, the 5 V part only its own.
    assign ov_fault   = flt_s.reg_ov | (v33_s & flt_s.ldo3_ov);                    // RULE_08
    assign uv_fault   = flt_s.reg_uv | (v33_s & flt_s.ldo3_uv);                    // RULE_08
    assign volt_fault = ov_fault | uv_fault;                                         // RULE_07

    // -------------------------------------------------------------------------
    // Dominant timeout
    // -------------------------------------------------------------------------
    logic                  dto_ff;       // Dominant timeout fault flag.
    logic [`CSM_DTO_W-1:0] dto_cnt_ff;   // Cycles transmit has stayed dominant.
    logic                  drv_active;   // Bus driver belongs to normal mode.
    logic                  txd_fall;
    logic                  txd_rise;
    csm_mode_e             mode_ff;
    csm_mode_e             nxt_mode;

    assign drv_active = (mode_ff == CSM_NORMAL);
    assign txd_fall   = txd_d_ff & ~txd_s;
    assign txd_rise   = ~txd_d_ff & txd_s;

    // A falling edge restarts the count; reaching the period raises the fault.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dto_cnt_ff <= 16'h0000;
            dto_ff     <= 1'b0;
        end else if (i_clk_en) begin
            if (txd_rise || !drv_active) begin
                dto_cnt_ff <= 16'h0000;
                dto_ff     <= 1'b0;                                                 // RULE_19
            end else if (txd_fall) begin
                dto_cnt_ff <= 16'h0001;                                             // RULE_17
            end else if (!txd_s && dto_cnt_ff != 16'h0000 && !dto_ff) begin
                dto_cnt_ff <= dto_cnt_ff + 16'h0001;
                if (dto_cnt_ff >= 16'(DTO_CYCLES - 1)) begin
                    dto_ff <= 1'b1;                                                 // RULE_24
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Local wake and external reset request
    // -------------------------------------------------------------------------
    logic                    wake_pend_ff;   // A wake is waiting out its delay.
    logic [`CSM_SHORT_W-1:0] wake_cnt_ff;    // Cycles since the wake edge.
    logic                    wake_done;
    logic [`CSM_SHORT_W-1:0] rin_cnt_ff;     // Cycles the reset line has been low.
    logic                    rst_req;

    assign wake_done = wake_pend_ff && (wake_cnt_ff >= 10'(`CSM_WAKE_CYCLES));      // RULE_22
    assign rst_req   = (rin_cnt_ff >= 10'(`CSM_RST_IN_CYCLES));                     // RULE_21

    // Either edge of the wake pin, or a bus wake, arms the wake delay in sleep.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wake_pend_ff <= 1'b0;
            wake_cnt_ff  <= 10'h000;
        end else if (i_clk_en) begin
            if (mode_ff != CSM_SLEEP) begin
                wake_pend_ff <= 1'b0;
                wake_cnt_ff  <= 10'h000;
            end else if (!wake_pend_ff && ((wake_s ^ wake_d_ff) || buswake_s)) begin
                wake_pend_ff <= 1'b1;                                               // RULE_12
                wake_cnt_ff  <= 10'h001;
            end else if (wake_pend_ff && !wake_done) begin
                wake_cnt_ff <= wake_cnt_ff + 10'h001;
            end
        end
    end

    // The line is only sampled as a request while the device leaves it free.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rin_cnt_ff <= 10'h000;
        end else if (i_clk_en) begin
            if ((mode_ff == CSM_NORMAL || mode_ff == CSM_STANDBY) && !rstin_s) begin
                if (!rst_req) begin
                    rin_cnt_ff <= rin_cnt_ff + 10'h001;                             // RULE_15
                end
            end else begin
                rin_cnt_ff <= 10'h000;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Mode state machine
    // -------------------------------------------------------------------------
    logic                    cold_ff;        // Current reset pulse is a cold crank.
    logic                    nxt_cold;
    logic [`CSM_PULSE_W-1:0] pls_cnt_ff;     // Cycles spent in reset mode.
    logic                    pulse_done;

    assign pulse_done = cold_ff ? (pls_cnt_ff >= 18'(COLD_CYCLES))
                                : (pls_cnt_ff >= 18'(WARM_CYCLES));                 // RULE_24

    // Next mode from the select input, the timers and the fault flags.
    always_comb begin
        nxt_mode = mode_ff;
        nxt_cold = cold_ff;
        case (mode_ff)
            CSM_SLEEP: begin
                if (wake_done) begin
                    nxt_mode = CSM_RESET;                                           // RULE_01
                    nxt_cold = 1'b1;                                                // RULE_14
                end
            end
            CSM_RESET: begin
                if (flt_s.overtemp_threshold || ov_fault) begin
                    nxt_mode = CSM_FAILSAFE;
                end else if (flt_s.io_supply_undervoltage) begin
                    nxt_mode = CSM_SLEEP;
                end else if (pulse_done && !uv_fault) begin
                    nxt_mode = CSM_STANDBY;
                end
            end
            CSM_STANDBY, CSM_NORMAL: begin
                if (flt_s.overtemp_threshold || ov_fault) begin
                    nxt_mode = CSM_FAILSAFE;
                end else if (uv_fault) begin
                    nxt_mode = CSM_RESET;
                    nxt_cold = 1'b1;                                                // RULE_14
                end else if (flt_s.io_supply_undervoltage || !sel_s) begin
                    nxt_mode = CSM_SLEEP;                                           // RULE_09
                end else if (rst_req) begin
                    nxt_mode = CSM_RESET;
                    nxt_cold = 1'b0;                                                // RULE_16
                end else begin
                    nxt_mode = CSM_NORMAL;                                          // RULE_09
                end
            end
            CSM_FAILSAFE: begin
                if (!flt_s.overtemp_threshold && !ov_fault) begin
                    nxt_mode = CSM_RESET;
                    nxt_cold = 1'b1;                                                // RULE_14
                end
            end
            default: begin
                nxt_mode = CSM_RESET;
                nxt_cold = 1'b1;
            end
        endcase
    end

    // Power-up enters reset as a cold crank; the pulse counter runs in reset.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_ff    <= CSM_RESET;
            cold_ff    <= 1'b1;                                                     // RULE_14
            pls_cnt_ff <= 18'h00000;
        end else if (i_clk_en) begin
            mode_ff <= nxt_mode;
            cold_ff <= nxt_cold;
            if (nxt_mode == CSM_RESET && mode_ff == CSM_RESET) begin
                if (!pulse_done) begin
                    pls_cnt_ff <= pls_cnt_ff + 18'h00001;
                end
            end else begin
                pls_cnt_ff <= 18'h00000;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------------
    // Outputs follow the next mode so they line up with the mode register.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_power_inhibit_out        <= 1'b1;
            o_power_inhibit_out_oe     <= 1'b1;
            o_system_reset_line_n      <= 1'b0;
            o_system_reset_line_n_oe   <= 1'b1;
            o_regulator_enable         <= 1'b1;
            o_mode                     <= CSM_RESET;
        end else if (i_clk_en) begin
            o_power_inhibit_out        <= 1'b1;                                     // RULE_10
            o_power_inhibit_out_oe     <= (nxt_mode != CSM_SLEEP);                  // RULE_11
            o_system_reset_line_n      <= 1'b0;
            o_system_reset_line_n_oe   <= (nxt_mode == CSM_RESET)
                                        || (nxt_mode == CSM_FAILSAFE);              // RULE_13
            o_regulator_enable         <= (nxt_mode != CSM_SLEEP);                  // RULE_02
            o_mode                     <= nxt_mode;
        end
    end

    // Transceiver side: status, receive data and the bus driver.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_transceiver_ready_out    <= 1'b0;
            o_transceiver_ready_out_oe <= 1'b0;
            o_rxd                      <= 1'b1;
            o_rxd_oe                   <= 1'b0;
            o_bus_driver_enable        <= 1'b0;
            o_dominant_timeout         <= 1'b0;
        end else if (i_clk_en) begin
            o_transceiver_ready_out    <= (mode_ff == CSM_NORMAL) && !dto_ff
                                        && !flt_s.overtemp_threshold && !volt_fault; // RULE_04 RULE_05
            o_transceiver_ready_out_oe <= !flt_s.io_supply_undervoltage;            // RULE_06
            o_rxd                      <= !busdom_s;                                // RULE_20
            o_rxd_oe                   <= !flt_s.io_supply_undervoltage;            // RULE_03
            o_bus_driver_enable        <= drv_active && !dto_ff;                    // RULE_18
            o_dominant_timeout         <= dto_ff;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst || !i_clk_en);

    sequence s_dom_held;
        !txd_s && !dto_ff && drv_active && dto_cnt_ff == 16'(DTO_CYCLES - 1);
    endsequence
    sequence s_rise_in_fault;
        dto_ff && txd_rise;
    endsequence

    inh_two_state_a: assert property (o_power_inhibit_out)                          // RULE_10
        else $error("Inhibit output driven low.");
    inh_mode_a: assert property (o_power_inhibit_out_oe == (mode_ff != CSM_SLEEP))   // RULE_11
        else $error("Inhibit drive does not match mode.");
    reg_sleep_a: assert property (o_regulator_enable == (mode_ff != CSM_SLEEP))      // RULE_02
        else $error("Regulator enable wrong for mode.");
    ts_ready_a: assert property (o_transceiver_ready_out |->
                                 $past(mode_ff) == CSM_NORMAL && !o_dominant_timeout) // RULE_04
        else $error("Status high outside clean normal mode.");
    ts_tristate_a: assert property ($past(flt_s.io_supply_undervoltage)
                                    |-> !o_transceiver_ready_out_oe && !o_rxd_oe)   // RULE_06
        else $error("Status or receive driven without I/O supply.");
    dto_set_a: assert property (s_dom_held ##1 !txd_s |-> ##1 !o_bus_driver_enable
                                && !o_transceiver_ready_out)                        // RULE_18
        else $error("Driver not released after dominant timeout.");
    dto_clear_a: assert property (s_rise_in_fault |=> !dto_ff)                      // RULE_19
        else $error("Timeout fault not cleared on recessive edge.");
    failsafe_rst_a: assert property (mode_ff == CSM_FAILSAFE |-> o_system_reset_line_n_oe
                                     && !o_system_reset_line_n)                     // RULE_13
        else $error("Reset line free in fail-safe.");
    wake_delay_a: assert property ($past(mode_ff) == CSM_SLEEP && mode_ff == CSM_RESET
                                   |-> $past(wake_cnt_ff) >= 10'(`CSM_WAKE_CYCLES))  // RULE_22
        else $error("Inhibit raised too soon after wake.");
    warm_len_a: assert property ($past(mode_ff) == CSM_RESET && mode_ff == CSM_STANDBY
                                 && !$past(cold_ff)
                                 |-> $past(pls_cnt_ff) == 18'(WARM_CYCLES))          // RULE_16
        else $error("Warm reset pulse has wrong length.");

endmodule : csm_mode_status

// *** csm_host_model.sv ***
`timescale 1ns/1ps
// Host side of the open-drain reset line, with the line's pull-up.
module csm_host_model (
    input  wire logic i_clock,
    input  wire logic i_req,     // One-cycle request for a reset.
    input  wire logic i_dev_oe,  // High while the device pulls low.
    output logic      o_line_n   // Resolved line level.
);
    int cnt_ff = 0;  // Remaining cycles of the host's own low pulse.
    // A request holds the line low for 160 cycles, above the least low time.
    always @(posedge i_clock) begin
        if (i_req) begin
            cnt_ff <= 160;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // The pull-up wins only when no party pulls low.
    assign o_line_n = !(i_dev_oe || (cnt_ff != 0));
endmodule : csm_host_model

// *** csm_mode_status_tb.sv ***
`timescale 1ns/1ps
module csm_mode_status_tb;
    import csm_pkg::*;
    localparam int DTO  = 40;   // Shortened counts for simulation.
    localparam int COLD = 200;
    localparam int WARM = 100;
    logic clk = 0, rst = 1, txd = 1, sel_n = 1, wake = 0, bus_dom = 0, v3 = 0, req = 0;
    logic power_inhibit_out, inh_oe, rl, rl_oe, rdy, rdy_oe, rxd, rxd_oe, drv, reg_en, dto, line_n;
    csm_fault_s flt = '0;
    csm_mode_e  mode;
    int failures = 0, checks_done = 0, cyc = 0, i;
    initial forever #50 clk = ~clk;
    csm_mode_status #(.DTO_CYCLES(DTO), .COLD_CYCLES(COLD), .WARM_CYCLES(WARM))
        i_csm_mode_status (.i_clock(clk), .i_rst(rst), .i_clk_en(1'b1), .i_txd(txd),
        .i_low_power_select_n(sel_n), .i_system_reset_line_n(line_n), .i_wake(wake),
        .i_bus_wake(1'b0), .i_bus_dominant(bus_dom), .i_variant_3v3(v3), .i_faults(flt),
        .o_power_inhibit_out(power_inhibit_out), .o_power_inhibit_out_oe(inh_oe),
        .o_system_reset_line_n(rl), .o_system_reset_line_n_oe(rl_oe),
        .o_transceiver_ready_out(rdy), .o_transceiver_ready_out_oe(rdy_oe), .o_rxd(rxd),
        .o_rxd_oe(rxd_oe), .o_bus_driver_enable(drv), .o_regulator_enable(reg_en),
        .o_dominant_timeout(dto), .o_mode(mode));
    csm_host_model i_csm_host_model (.i_clock(clk), .i_req(req), .i_dev_oe(rl_oe),
        .o_line_n(line_n));
    // Compares one result and counts it.
    task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Waits a bounded time for a mode.
    task automatic to_mode(input csm_mode_e m);
        int k;
        k = 0;
        while (mode !== m && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk("mode", m, mode);
    endtask : to_mode
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // A hang counts as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        idle(6);
        rst = 0;
        idle(1);
        chk("mode", CSM_RESET, mode);
        chk("rst_oe", 1, rl_oe);
        to_mode(CSM_NORMAL);
        idle(3);
        chk("ready", 1, rdy);
        chk("inh_oe", 1, inh_oe);
        chk("reg", 1, reg_en);
        $display("Test power-up done");
        txd = 0;
        idle(DTO - 10);
        chk("dto", 0, dto);
        txd = 1;
        idle(3);
        txd = 0;
        bus_dom = 1;
        idle(DTO + 10);
        chk("drv", 0, drv);
        chk("dto", 1, dto);
        chk("ready", 0, rdy);
        chk("rxd", 0, rxd);
        txd = 1;
        bus_dom = 0;
        idle(5);
        chk("drv", 1, drv);
        chk("ready", 1, rdy);
        $display("Test timeout done");
        req = 1;
        idle(1);
        req = 0;
        to_mode(CSM_RESET);
        idle(WARM - 20);
        chk("rst_oe", 1, rl_oe);
        idle(30);
        chk("rst_oe", 0, rl_oe);
        to_mode(CSM_NORMAL);
        $display("Test warm reset done");
        for (i = 0; i < 5; i++) begin
            v3 = (i < 2);
            flt = 6'h01 << ((i == 4) ? 5 : i);
            idle(5);
            chk("ready", 0, rdy);
            if (i % 2 == 0) chk("rst_oe", 1, rl_oe);
            flt = '0;
            to_mode(CSM_NORMAL);
        end
        $display("Test faults done");
        sel_n = 0;
        to_mode(CSM_SLEEP);
        idle(2);
        chk("inh_oe", 0, inh_oe);
        chk("inh", 1, power_inhibit_out);
        chk("reg", 0, reg_en);
        wake = 1;
        idle(300);
        chk("inh_oe", 0, inh_oe);
        idle(120);
        chk("inh_oe", 1, inh_oe);
        to_mode(CSM_SLEEP);
        wake = 0;
        idle(420);
        chk("inh_oe", 1, inh_oe);
        $display("Test wake done");
        sel_n = 1;
        to_mode(CSM_NORMAL);
        flt.io_supply_undervoltage = 1;
        idle(5);
        chk("ready_oe", 0, rdy_oe);
        chk("rxd_oe", 0, rxd_oe);
        $display("Test io supply done");
        finish_test();
    end
endmodule : csm_mode_status_tb
